// *** i2cmt_pkg.sv ***
package i2cmt_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 2;
  localparam logic [ADDR_W-1:0] REG_CTRL = 2'h0;
  localparam logic [ADDR_W-1:0] REG_STATUS = 2'h1;
  localparam logic [ADDR_W-1:0] REG_DATA = 2'h2;
  localparam logic [ADDR_W-1:0] REG_RATE = 2'h3;

  // control register fields
  localparam int CB_FLAG = 7;
  localparam int CB_ACKEN = 6;
  localparam int CB_STA = 5;
  localparam int CB_STO = 4;
  localparam int CB_WC = 3;
  localparam int CB_EN = 2;
  localparam int CB_IE = 0;

  // status register fields
  localparam int SB_CODE_LO = 3;
  localparam int PRE_W = 2;
  localparam logic [7:0] STATUS_MASK = 8'hf8;

  // status codes, prescaler bits zero
  localparam logic [7:0] SC_START = 8'h08;
  localparam logic [7:0] SC_RSTART = 8'h10;
  localparam logic [7:0] SC_AW_ACK = 8'h18;
  localparam logic [7:0] SC_AW_NACK = 8'h20;
  localparam logic [7:0] SC_D_ACK = 8'h28;
  localparam logic [7:0] SC_D_NACK = 8'h30;
  localparam logic [7:0] SC_ARB = 8'h38;
  localparam logic [7:0] SC_AR_ACK = 8'h40;
  localparam logic [7:0] SC_AR_NACK = 8'h48;
  localparam logic [7:0] SC_NONE = 8'hf8;

  // reset values and bit timing
  localparam logic [7:0] RATE_RST = 8'h04;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [1:0] PH_SET = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_HIGH = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } i2cmt_bus_req_t;

  typedef struct packed {
    logic scl_oe;
    logic sda_oe;
  } i2cmt_pin_drv_t;

  typedef enum logic [7:0] {
    S_IDLE = 8'b0000_0001,
    S_WAIT_FREE = 8'b0000_0010,
    S_START = 8'b0000_0100,
    S_HOLD = 8'b0000_1000,
    S_XFER = 8'b0001_0000,
    S_RSTART = 8'b0010_0000,
    S_STOP = 8'b0100_0000,
    S_LOST = 8'b1000_0000
  } i2cmt_state_t;

endpackage

// *** i2cmt_sync.sv ***
`timescale 1ns/1ps
module i2cmt_sync (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_async,
  output logic o_sync
);
  // ----------------------------------------------------------------
  // two flop synchroniser, idle high
  // ----------------------------------------------------------------
  logic meta_q;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= 1'b1;
      o_sync <= 1'b1;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// *** i2cmt_tick.sv ***
`timescale 1ns/1ps
module i2cmt_tick #(
  parameter int W = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_div,
  output logic o_tick
);
  // ----------------------------------------------------------------
  // quarter bit enable, one pulse every i_div+1 cycles
  // ----------------------------------------------------------------
  logic [W-1:0] cnt_q;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
      o_tick <= 1'b0;
    end else if (cnt_q >= i_div) begin
      cnt_q <= '0;
      o_tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      o_tick <= 1'b0;
    end
  end
endmodule

// *** i2cmt_master_tx.sv ***
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
module i2cmt_master_tx #(
  parameter logic [7:0] RATE_DEFAULT = i2cmt_pkg::RATE_RST
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire i2cmt_pkg::i2cmt_bus_req_t i_bus_req,
  output logic [7:0] o_rdata,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_scl_oe,
  output logic o_sda,
  output logic o_sda_oe,
  output logic o_slave_mode,
  output logic o_master_rx
);
  import i2cmt_pkg::*;

  // ----------------------------------------------------------------
  // pin sampling and bus state
  // ----------------------------------------------------------------
  logic scl_s;
  logic sda_s;
  logic scl_p_q;
  logic sda_p_q;
  logic busy_q;
  logic tick;

  i2cmt_sync u_sync_scl (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_async(i_scl),
    .o_sync(scl_s)
  );

  i2cmt_sync u_sync_sda (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_async(i_sda),
    .o_sync(sda_s)
  );

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // start seen marks busy, stop seen marks free
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_q <= 1'b0;
    end else if (scl_s && scl_p_q && sda_p_q && !sda_s) begin
      busy_q <= 1'b1;
    end else if (scl_s && scl_p_q && !sda_p_q && sda_s) begin
      busy_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic flag_q;
  logic acken_q;
  logic sta_q;
  logic sto_q;
  logic wc_q;
  logic en_q;
  logic ie_q;
  logic [7:SB_CODE_LO] code_q;
  logic [PRE_W-1:0] pre_q;
  logic [7:0] data_q;
  logic [7:0] rate_q;
  logic wr_ctrl;
  logic wr_data;
  logic clr;
  logic post;
  logic [7:0] post_code;
  logic sto_clr;

  assign wr_ctrl = i_bus_req.wr && (i_bus_req.addr == REG_CTRL);
  assign wr_data = i_bus_req.wr && (i_bus_req.addr == REG_DATA);
  assign clr = wr_ctrl && i_bus_req.wdata[CB_FLAG] && i_bus_req.wdata[CB_EN];

  i2cmt_tick #(
    .W(8)
  ) u_tick (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_div(rate_q),
    .o_tick(tick)
  );

  // step-done flag, hardware set wins over software clear
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_q <= 1'b0;
    end else if (post) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acken_q <= 1'b0;
      sta_q <= 1'b0;
      en_q <= 1'b0;
      ie_q <= 1'b0;
    end else if (wr_ctrl) begin
      acken_q <= i_bus_req.wdata[CB_ACKEN];
      sta_q <= i_bus_req.wdata[CB_STA];
      en_q <= i_bus_req.wdata[CB_EN];
      ie_q <= i_bus_req.wdata[CB_IE];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sto_q <= 1'b0;
    end else if (wr_ctrl) begin
      sto_q <= i_bus_req.wdata[CB_STO];
    end else if (sto_clr) begin
      sto_q <= 1'b0;
    end
  end

  // data loads only while the flag is up
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_q <= '0;
      wc_q <= 1'b0;
    end else if (wr_data && !flag_q) begin
      wc_q <= 1'b1;
    end else if (wr_data) begin
      data_q <= i_bus_req.wdata;
      wc_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_q <= '0;
      rate_q <= RATE_DEFAULT;
    end else if (i_bus_req.wr && (i_bus_req.addr == REG_STATUS)) begin
      pre_q <= i_bus_req.wdata[PRE_W-1:0];
    end else if (i_bus_req.wr && (i_bus_req.addr == REG_RATE)) begin
      rate_q <= i_bus_req.wdata;
    end
  end

  // status code field, prescaler kept apart
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      code_q <= SC_NONE[7:SB_CODE_LO];
    end else if (post) begin
      code_q <= post_code[7:SB_CODE_LO];
    end else if (clr) begin
      code_q <= SC_NONE[7:SB_CODE_LO];
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= '0;
    end else if (i_bus_req.rd) begin
      unique case (i_bus_req.addr)
        REG_CTRL: o_rdata <= {flag_q, acken_q, sta_q, sto_q, wc_q, en_q, 1'b0, ie_q};
        REG_STATUS: o_rdata <= {code_q, 1'b0, pre_q};
        REG_DATA: o_rdata <= data_q;
        REG_RATE: o_rdata <= rate_q;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

  // ----------------------------------------------------------------
  // bus sequencer
  // ----------------------------------------------------------------
  i2cmt_state_t state_q;
  i2cmt_state_t state_d;
  logic [1:0] ph_q;
  logic [1:0] ph_d;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  i2cmt_pin_drv_t drv_q;
  i2cmt_pin_drv_t drv_d;
  logic addr_q;
  logic addr_d;
  logic rd_dir_q;
  logic rd_dir_d;
  logic nack_q;
  logic nack_d;
  logic lost;
  logic step;
  logic new_sta;
  logic new_sto;

  assign step = tick && !((ph_q == PH_HIGH) && !scl_s);
  assign new_sta = i_bus_req.wdata[CB_STA];
  assign new_sto = i_bus_req.wdata[CB_STO];

  always_comb begin
    state_d = state_q;
    ph_d = ph_q;
    bit_d = bit_q;
    shift_d = shift_q;
    drv_d = drv_q;
    addr_d = addr_q;
    rd_dir_d = rd_dir_q;
    nack_d = nack_q;
    post = 1'b0;
    post_code = SC_NONE;
    sto_clr = 1'b0;
    lost = 1'b0;
    if (!en_q && !clr) begin
      state_d = S_IDLE;
      drv_d = '0;
    end else begin
      unique case (state_q)
        S_IDLE: begin
          if (clr && new_sta) begin
            state_d = S_WAIT_FREE;
          end
        end
        S_WAIT_FREE: begin
          if (tick && !busy_q && scl_s && sda_s) begin
            state_d = S_START;
            ph_d = PH_SET;
          end
        end
        S_START: begin
          if (step) begin
            if (ph_q == PH_SET) begin
              drv_d.sda_oe = 1'b1;
              ph_d = PH_RISE;
            end else begin
              drv_d.scl_oe = 1'b1;
              post = 1'b1;
              post_code = SC_START;
              addr_d = 1'b1;
              state_d = S_HOLD;
            end
          end
        end
        S_HOLD: begin
          drv_d.scl_oe = 1'b1;
          if (clr) begin
            ph_d = PH_SET;
            if (new_sto) begin
              state_d = S_STOP;
            end else if (new_sta) begin
              state_d = S_RSTART;
            end else if (!(rd_dir_q && !addr_q)) begin
              state_d = S_XFER;
              shift_d = data_q;
              bit_d = '0;
              if (addr_q) begin
                rd_dir_d = data_q[0];
              end
            end
          end
        end
        S_XFER: begin
          if (step) begin
            unique case (ph_q)
              PH_SET: begin
                drv_d.sda_oe = (bit_q != BIT_ACK) && !shift_q[7];
                ph_d = PH_RISE;
              end
              PH_RISE: begin
                drv_d.scl_oe = 1'b0;
                ph_d = PH_HIGH;
              end
              PH_HIGH: begin
                if ((bit_q != BIT_ACK) && !drv_q.sda_oe && !sda_s) begin
                  lost = 1'b1;
                end else if (bit_q == BIT_ACK) begin
                  nack_d = sda_s;
                end else begin
                  shift_d = {shift_q[6:0], 1'b0};
                end
                ph_d = PH_FALL;
              end
              PH_FALL: begin
                drv_d.scl_oe = 1'b1;
                ph_d = PH_SET;
                if (bit_q == BIT_ACK) begin
                  post = 1'b1;
                  state_d = S_HOLD;
                  addr_d = 1'b0;
                  if (addr_q && rd_dir_q) begin
                    post_code = nack_q ? SC_AR_NACK : SC_AR_ACK;
                  end else if (addr_q) begin
                    post_code = nack_q ? SC_AW_NACK : SC_AW_ACK;
                  end else begin
                    post_code = nack_q ? SC_D_NACK : SC_D_ACK;
                  end
                end else begin
                  bit_d = bit_q + 4'h1;
                end
              end
            endcase
          end
          if (lost) begin
            drv_d = '0;
            post = 1'b1;
            post_code = SC_ARB;
            state_d = S_LOST;
          end
        end
        S_RSTART: begin
          if (step) begin
            ph_d = ph_q + 2'h1;
            unique case (ph_q)
              PH_SET: drv_d.sda_oe = 1'b0;
              PH_RISE: drv_d.scl_oe = 1'b0;
              PH_HIGH: drv_d.sda_oe = 1'b1;
              PH_FALL: begin
                drv_d.scl_oe = 1'b1;
                post = 1'b1;
                post_code = SC_RSTART;
                addr_d = 1'b1;
                rd_dir_d = 1'b0;
                state_d = S_HOLD;
              end
            endcase
          end
        end
        S_STOP: begin
          if (step) begin
            ph_d = ph_q + 2'h1;
            unique case (ph_q)
              PH_SET: drv_d.sda_oe = 1'b1;
              PH_RISE: drv_d.scl_oe = 1'b0;
              PH_HIGH: drv_d.sda_oe = 1'b0;
              PH_FALL: begin
                sto_clr = 1'b1;
                rd_dir_d = 1'b0;
                state_d = sta_q ? S_WAIT_FREE : S_IDLE;
              end
            endcase
          end
        end
        S_LOST: begin
          if (clr) begin
            rd_dir_d = 1'b0;
            state_d = new_sta ? S_WAIT_FREE : S_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= S_IDLE;
      ph_q <= PH_SET;
      bit_q <= '0;
      shift_q <= '0;
      drv_q <= '0;
      addr_q <= 1'b0;
      rd_dir_q <= 1'b0;
      nack_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ph_q <= ph_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      drv_q <= drv_d;
      addr_q <= addr_d;
      rd_dir_q <= rd_dir_d;
      nack_q <= nack_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_slave_mode <= 1'b0;
      o_master_rx <= 1'b0;
    end else begin
      o_slave_mode <= (state_d == S_LOST);
      o_master_rx <= rd_dir_d && !addr_d && (state_d == S_HOLD);
    end
  end

  assign o_scl = 1'b0;
  assign o_sda = 1'b0;
  assign o_scl_oe = drv_q.scl_oe;
  assign o_sda_oe = drv_q.sda_oe;

endmodule

// *** i2cmt_master_tx_sva.sv ***
`timescale 1ns/1ps
module i2cmt_master_tx_sva (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire i2cmt_pkg::i2cmt_bus_req_t i_bus_req,
  input wire logic [7:0] o_rdata,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_scl,
  input wire logic o_scl_oe,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic o_slave_mode,
  input wire logic o_master_rx
);
  import i2cmt_pkg::*;
  // ----
  // port checks
  // ----
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_start;
    !o_scl_oe && $rose(o_sda_oe);
  endsequence
  sequence s_stop;
    !o_scl_oe && i_scl && $fell(o_sda_oe);
  endsequence
  property p_start_free;
    s_start |-> i_scl && $past(i_sda);
  endproperty
  a_start_free: assert property (p_start_free)
    else $error("start while bus not free");
  property p_start_clk;
    s_start |-> ##[1:20] o_scl_oe;
  endproperty
  a_start_clk: assert property (p_start_clk)
    else $error("clock not taken after start");
  property p_stop_quiet;
    s_stop |=> !o_scl_oe [*2];
  endproperty
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("clock pulled right after stop");
  property p_rd_idle;
    !i_bus_req.rd |=> o_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read cycle");
  property p_rx_hold;
    o_master_rx && !i_bus_req.wr && !$past(i_bus_req.wr) |=> o_master_rx && o_scl_oe;
  endproperty
  a_rx_hold: assert property (p_rx_hold)
    else $error("suspension left without write");
  property p_lost_free;
    o_slave_mode && $past(o_slave_mode) |-> !o_scl_oe && !o_sda_oe;
  endproperty
  a_lost_free: assert property (p_lost_free)
    else $error("bus held after arbitration loss");
  property p_open_drain;
    o_scl == 1'b0 && o_sda == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("pin data not low");
  property p_mode_excl;
    !(o_slave_mode && o_master_rx);
  endproperty
  a_mode_excl: assert property (p_mode_excl)
    else $error("two modes at once");
endmodule
bind i2cmt_master_tx i2cmt_master_tx_sva i2cmt_master_tx_sva_i (.i_clk_sys(i_clk_sys),
  .i_rst_n(i_rst_n), .i_bus_req(i_bus_req), .o_rdata(o_rdata), .i_scl(i_scl), .i_sda(i_sda),
  .o_scl(o_scl), .o_scl_oe(o_scl_oe), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
  .o_slave_mode(o_slave_mode), .o_master_rx(o_master_rx));

// *** i2cmt_slave_model.sv ***
`timescale 1ns/1ps
module i2cmt_slave_model (
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_nack,
  input wire logic i_arb,
  input wire logic i_stretch,
  output logic o_scl_oe,
  output logic o_sda_oe,
  output logic [7:0] o_byte
);
  // ----
  // slave receiver and rival master
  // ----
  logic [3:0] cnt = 4'hf;
  logic [7:0] sh = 8'h00;
  logic frame = 1'b0;
  logic ack = 1'b0;
  initial o_scl_oe = 1'b0;
  initial o_byte = 8'h00;
  assign o_sda_oe = ack || (i_arb && frame && cnt == 4'h0);
  always @(negedge i_sda) if (i_scl) begin
    frame = 1'b1;
    cnt = 4'hf;
  end
  always @(posedge i_sda) if (i_scl) frame = 1'b0;
  always @(posedge i_scl) if (frame && cnt < 4'h8) sh = {sh[6:0], i_sda};
  always @(negedge i_scl) if (frame) begin
    cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
    if (cnt == 4'h8) o_byte = sh;
    ack = (cnt == 4'h8) && !i_nack;
    if (i_stretch) begin
      o_scl_oe = 1'b1;
      #500 o_scl_oe = 1'b0;
    end
  end
endmodule

// *** i2c_master_transmitter_tb_top.sv ***
`timescale 1ns/1ps
module i2c_master_transmitter_tb_top;
  import i2cmt_pkg::*;
  // ----
  // bench
  // ----
  typedef struct packed {
    logic ld;
    logic [7:0] dat;
    logic [7:0] ctl;
    logic nk;
    logic wf;
    logic [7:0] st;
    logic [7:0] ec;
    logic mrx;
  } i2cmt_row_t;
  localparam i2cmt_row_t ROWS [12] = '{
    '{1'b0, 8'h00, 8'ha4, 1'b0, 1'b1, 8'h08, 8'hac, 1'b0},
    '{1'b1, 8'h50, 8'h84, 1'b0, 1'b1, 8'h18, 8'h84, 1'b0},
    '{1'b1, 8'ha5, 8'h84, 1'b0, 1'b1, 8'h28, 8'h84, 1'b0},
    '{1'b0, 8'h00, 8'ha4, 1'b0, 1'b1, 8'h10, 8'ha4, 1'b0},
    '{1'b1, 8'h50, 8'h84, 1'b0, 1'b1, 8'h18, 8'h84, 1'b0},
    '{1'b1, 8'h3c, 8'h84, 1'b1, 1'b1, 8'h30, 8'h84, 1'b0},
    '{1'b0, 8'h00, 8'h94, 1'b0, 1'b0, 8'hf8, 8'h04, 1'b0},
    '{1'b0, 8'h00, 8'ha4, 1'b0, 1'b1, 8'h08, 8'ha4, 1'b0},
    '{1'b1, 8'h52, 8'h84, 1'b1, 1'b1, 8'h20, 8'h84, 1'b0},
    '{1'b0, 8'h00, 8'hb4, 1'b0, 1'b1, 8'h08, 8'ha4, 1'b0},
    '{1'b1, 8'h51, 8'h84, 1'b1, 1'b1, 8'h48, 8'h84, 1'b1},
    '{1'b0, 8'h00, 8'h94, 1'b0, 1'b0, 8'hf8, 8'h04, 1'b0}};
  localparam logic [7:0] RST [4] = '{8'h00, 8'hf8, 8'h00, 8'h01};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  i2cmt_bus_req_t req = '0;
  logic [7:0] rdata;
  logic [7:0] sbyte;
  logic [7:0] v;
  logic scl_oe, sda_oe, s_scl_oe, s_sda_oe, slv_mode, mrx;
  logic nk = 1'b0;
  logic arb = 1'b0;
  logic str = 1'b0;
  int errors = 0;
  int checked = 0;
  wire logic scl = !(scl_oe || s_scl_oe);
  wire logic sda = !(sda_oe || s_sda_oe);
  always #20 clk = !clk;
  i2cmt_master_tx #(.RATE_DEFAULT(8'h01)) i2cmt_master_tx_i (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_bus_req(req), .o_rdata(rdata), .i_scl(scl), .i_sda(sda), .o_scl(), .o_scl_oe(scl_oe),
    .o_sda(), .o_sda_oe(sda_oe), .o_slave_mode(slv_mode), .o_master_rx(mrx));
  i2cmt_slave_model i2cmt_slave_model_i (.i_scl(scl), .i_sda(sda), .i_nack(nk), .i_arb(arb),
    .i_stretch(str), .o_scl_oe(s_scl_oe), .o_sda_oe(s_sda_oe), .o_byte(sbyte));
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    #1 v = rdata;
  endtask
  task automatic poll(input int b, input logic e);
    int n;
    for (n = 0; n < 400; n++) begin
      rd(REG_CTRL);
      if (v[b] === e) break;
    end
    if (n == 400) chk(8'h00, 8'h01, "wait timeout");
  endtask
  task automatic test_done();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    #1000000;
    errors++;
    test_done();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      rd(2'(k));
      chk(v, RST[k], "reset value");
    end
    wr(REG_STATUS, 8'h03);
    rd(REG_STATUS);
    chk(v, 8'hfb, "prescaler");
    wr(REG_DATA, 8'h11);
    rd(REG_CTRL);
    chk(v, 8'h08, "collision");
    rd(REG_DATA);
    chk(v, 8'h00, "dropped write");
    $display("reset and collision test done");
    for (int i = 0; i < 12; i++) begin
      nk <= ROWS[i].nk;
      str <= (i == 4 || i == 5);
      if (ROWS[i].ld) wr(REG_DATA, ROWS[i].dat);
      wr(REG_CTRL, ROWS[i].ctl);
      if (ROWS[i].wf) poll(CB_FLAG, 1'b1);
      else poll(CB_STO, 1'b0);
      rd(REG_STATUS);
      chk(v & STATUS_MASK, ROWS[i].st, "status");
      rd(REG_CTRL);
      chk(v, ROWS[i].ec, "ctrl");
      if (ROWS[i].ld) chk(sbyte, ROWS[i].dat, "byte on bus");
      chk({7'h00, mrx}, {7'h00, ROWS[i].mrx}, "receive mode");
      $display("row %0d done", i);
    end
    wr(REG_CTRL, 8'ha4);
    poll(CB_FLAG, 1'b1);
    wr(REG_DATA, 8'hfe);
    arb <= 1'b1;
    wr(REG_CTRL, 8'h84);
    poll(CB_FLAG, 1'b1);
    rd(REG_STATUS);
    chk(v & STATUS_MASK, SC_ARB, "lost");
    chk({6'h00, scl_oe, sda_oe}, 8'h00, "released");
    chk({7'h00, slv_mode}, 8'h01, "slave mode");
    wr(REG_CTRL, 8'ha4);
    repeat (40) @(posedge clk);
    rd(REG_CTRL);
    chk(v & 8'h80, 8'h00, "busy wait");
    arb <= 1'b0;
    poll(CB_FLAG, 1'b1);
    rd(REG_STATUS);
    chk(v & STATUS_MASK, SC_START, "retry");
    wr(REG_CTRL, 8'h94);
    poll(CB_STO, 1'b0);
    $display("arbitration test done");
    wr(REG_CTRL, 8'ha4);
    poll(CB_FLAG, 1'b1);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    #1 chk({6'h00, scl_oe, sda_oe}, 8'h00, "drive in reset");
    @(posedge clk);
    rst_n <= 1'b1;
    rd(REG_CTRL);
    chk(v, 8'h00, "ctrl after reset");
    rd(REG_STATUS);
    chk(v, 8'hf8, "status after reset");
    $display("mid-run reset test done");
    test_done();
  end
endmodule
